// >>> core/acpm_top.sv
// Pin multiplexer for the comparator pin group and the analog pin group.
// Assumes a Wishbone fabric that flags which master owns the cycle, and
// comparator outputs and pin levels that are asynchronous to core_clk.
// Behaviour
// RULE1 - Comparator pins: GPIO in, out or comparator
// RULE2 - Pullup off when disable bit is one
// RULE3 - Comparator pins reset undriven, digital off
// RULE4 - Only control CPU may change configuration
// RULE5 - Two-bit field per pin picks mode
// RULE6 - Mode 3 maps comparators per table
// RULE7 - Modes 1 and 2 connect nothing
// RULE8 - Comparator group data and direction registers
// RULE9 - Analog pins route analog or digital
// RULE10 - Analog group digital pins lack pullups
// RULE11 - Analog pins reset as analog inputs
// RULE12 - Odd select bit: 0 digital, 1 analog
// RULE13 - Bit 5 switches pin A2 routing
// RULE14 - Even analog select bits ignored
// RULE15 - Analog group six data, direction bits
// RULE16 - Field at 2k; digital n at 2n+1
// RULE17 - Pins without digital stay analog
`timescale 1ns/1ps
`default_nettype none

module acpm_top
  import acpm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire acpm_wb_req_t wb_req,
  input wire logic wb_ctl_cpu,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Comparator digital outputs, comparator 1 in bit 0
  input wire logic [CMP_SRCS-1:0] comparator_digital_output,
  // Comparator pin group pads
  input wire logic [CMP_PINS-1:0] cmp_pin_i,
  output logic [CMP_PINS-1:0] cmp_pin_o,
  output logic [CMP_PINS-1:0] cmp_pin_oe,
  output logic [CMP_PINS-1:0] cmp_pullup_en,
  // Analog pin group pads
  input wire logic [ANA_PINS-1:0] ana_pin_i,
  output logic [ANA_PINS-1:0] ana_pin_o,
  output logic [ANA_PINS-1:0] ana_pin_oe,
  output logic [ANA_PINS-1:0] ana_analog_en
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdat_q;
  wire req = wb_req.cyc && wb_req.stb && !ack_q;
  wire wr_ok = req && wb_req.we && wb_ctl_cpu; // RULE4
  wire rd_ok = req && !wb_req.we && wb_ctl_cpu;
  wire hit_cmp_sel = wb_req.adr == OFS_CMP_SEL;
  wire hit_cmp_pud = wb_req.adr == OFS_CMP_PUD;
  wire hit_cmp_dat = wb_req.adr == OFS_CMP_DAT;
  wire hit_cmp_dir = wb_req.adr == OFS_CMP_DIR;
  wire hit_ana_sel = wb_req.adr == OFS_ANA_SEL;
  wire hit_ana_dat = wb_req.adr == OFS_ANA_DAT;
  wire hit_ana_dir = wb_req.adr == OFS_ANA_DIR;
  wire [31:0] be_mask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}}, {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [15:0] cmp_sel_q;
  logic [7:0] cmp_pud_q;
  logic [7:0] cmp_dat_q;
  logic [7:0] cmp_dir_q;
  logic [31:0] ana_sel_q;
  logic [5:0] ana_dat_q;
  logic [5:0] ana_dir_q;

  wire [31:0] cmp_sel_d = merge({16'h0000, cmp_sel_q}, wb_req.dat, be_mask);
  wire [31:0] cmp_pud_d = merge({24'h000000, cmp_pud_q}, wb_req.dat, be_mask);
  wire [31:0] cmp_dat_d = merge({24'h000000, cmp_dat_q}, wb_req.dat, be_mask);
  wire [31:0] cmp_dir_d = merge({24'h000000, cmp_dir_q}, wb_req.dat, be_mask);
  wire [31:0] ana_sel_d = merge(ana_sel_q, wb_req.dat, be_mask);
  wire [31:0] ana_dat_d = merge({26'h0000000, ana_dat_q}, wb_req.dat, be_mask);
  wire [31:0] ana_dir_d = merge({26'h0000000, ana_dir_q}, wb_req.dat, be_mask);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmp_sel_q <= RST_CMP_SEL; // RULE3
      cmp_pud_q <= RST_CMP_PUD;
      cmp_dat_q <= RST_CMP_DAT;
      cmp_dir_q <= RST_CMP_DIR; // RULE3
      ana_sel_q <= RST_ANA_SEL; // RULE11
      ana_dat_q <= RST_ANA_DAT;
      ana_dir_q <= RST_ANA_DIR;
    end else if (wr_ok) begin
      if (hit_cmp_sel) cmp_sel_q <= cmp_sel_d[15:0]; // RULE5
      if (hit_cmp_pud) cmp_pud_q <= cmp_pud_d[7:0]; // RULE2
      if (hit_cmp_dat) cmp_dat_q <= cmp_dat_d[7:0]; // RULE8
      if (hit_cmp_dir) cmp_dir_q <= cmp_dir_d[7:0]; // RULE8
      if (hit_ana_sel) ana_sel_q <= ana_sel_d; // RULE9
      if (hit_ana_dat) ana_dat_q <= ana_dat_d[5:0]; // RULE15
      if (hit_ana_dir) ana_dir_q <= ana_dir_d[5:0]; // RULE15
    end
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Pins and comparators run free of core_clk, so two stages each
  logic [CMP_PINS-1:0] cmp_pin_m_q;
  logic [CMP_PINS-1:0] cmp_pin_s_q;
  logic [ANA_PINS-1:0] ana_pin_m_q;
  logic [ANA_PINS-1:0] ana_pin_s_q;
  logic [CMP_SRCS-1:0] comp_m_q;
  logic [CMP_SRCS-1:0] comp_s_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmp_pin_m_q <= '0;
      cmp_pin_s_q <= '0;
      ana_pin_m_q <= '0;
      ana_pin_s_q <= '0;
      comp_m_q <= '0;
      comp_s_q <= '0;
    end else begin
      cmp_pin_m_q <= cmp_pin_i;
      cmp_pin_s_q <= cmp_pin_m_q;
      ana_pin_m_q <= ana_pin_i;
      ana_pin_s_q <= ana_pin_m_q;
      comp_m_q <= comparator_digital_output;
      comp_s_q <= comp_m_q;
    end
  end

  // Analog digital inputs gathered by digital bit number
  logic [ANA_DIGS-1:0] ana_dig_in;
  always_comb begin
    ana_dig_in = '0;
    for (int p = 0; p < ANA_PINS; p++) begin
      if (ANA_DIG_MAP[3*p +: 3] != DIG_NONE) begin
        ana_dig_in[ANA_DIG_MAP[3*p +: 3]] = ana_pin_s_q[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Reads of the data registers return the pin level, not the latch
  wire [31:0] rd_mux =
    hit_cmp_sel ? {16'h0000, cmp_sel_q} :
    hit_cmp_pud ? {24'h000000, cmp_pud_q} :
    hit_cmp_dat ? {24'h000000, cmp_pin_s_q} :
    hit_cmp_dir ? {24'h000000, cmp_dir_q} :
    hit_ana_sel ? ana_sel_q :
    hit_ana_dat ? {26'h0000000, ana_dig_in} :
    hit_ana_dir ? {26'h0000000, ana_dir_q} :
    32'h00000000;

  // Foreign masters still get an ack so the fabric never hangs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      rdat_q <= rd_ok ? rd_mux : 32'h00000000; // RULE4
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ---------------------------------------------------------------
  // Comparator pin group
  // ---------------------------------------------------------------
  logic [CMP_PINS-1:0] cmp_o_q;
  logic [CMP_PINS-1:0] cmp_oe_q;

  for (genvar k = 0; k < CMP_PINS; k++) begin : g_cmp
    wire [1:0] mode = cmp_sel_q[2*k+1:2*k]; // RULE16
    wire [2:0] src = CMP_SRC_MAP[3*k +: 3];
    wire has_src = src != SRC_NONE;
    wire comp_bit = has_src ? comp_s_q[src] : 1'b0; // RULE6
    wire o_d = (mode == MODE_CMP) ? comp_bit : cmp_dat_q[k]; // RULE1
    // Reserved modes and empty table slots leave the pin undriven
    wire oe_d = (mode == MODE_GPIO) ? cmp_dir_q[k] :
                (mode == MODE_CMP) ? has_src : 1'b0; // RULE7
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        cmp_o_q[k] <= 1'b0;
        cmp_oe_q[k] <= 1'b0; // RULE3
      end else begin
        cmp_o_q[k] <= o_d;
        cmp_oe_q[k] <= oe_d;
      end
    end
  end

  assign cmp_pin_o = cmp_o_q;
  assign cmp_pin_oe = cmp_oe_q;
  assign cmp_pullup_en = ~cmp_pud_q; // RULE2

  // ---------------------------------------------------------------
  // Analog pin group
  // ---------------------------------------------------------------
  logic [ANA_PINS-1:0] ana_o_q;
  logic [ANA_PINS-1:0] ana_oe_q;
  logic [ANA_PINS-1:0] ana_en_q;

  for (genvar p = 0; p < ANA_PINS; p++) begin : g_ana
    localparam logic [3:0] NUM = ANA_NUM_MAP[4*p +: 4];
    localparam logic [2:0] DIG = ANA_DIG_MAP[3*p +: 3];
    localparam bit HAS_DIG = DIG != DIG_NONE;
    // Analog-only pins index bit 0 so no select runs out of range
    localparam int unsigned DIX = HAS_DIG ? int'(DIG) : 0;
    // Only the odd bit is consulted; the even bit never reaches here
    wire odd_bit = ana_sel_q[2*NUM+1]; // RULE16 RULE14
    wire digital = HAS_DIG && (odd_bit == MODE_ANA_DIGITAL); // RULE12 RULE17
    wire o_d = HAS_DIG ? ana_dat_q[DIX] : 1'b0;
    wire oe_d = digital && (HAS_DIG ? ana_dir_q[DIX] : 1'b0); // RULE15
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        ana_o_q[p] <= 1'b0;
        ana_oe_q[p] <= 1'b0;
        ana_en_q[p] <= 1'b1; // RULE11
      end else begin
        ana_o_q[p] <= o_d;
        ana_oe_q[p] <= oe_d; // RULE13
        ana_en_q[p] <= !digital; // RULE9
      end
    end
  end

  // No pullup output exists for this group
  assign ana_pin_o = ana_o_q; // RULE10
  assign ana_pin_oe = ana_oe_q;
  assign ana_analog_en = ana_en_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_foreign_wr;
    req && wb_req.we && !wb_ctl_cpu;
  endsequence

  sequence s_sel_hold;
    $stable(cmp_sel_q) && $stable(ana_sel_q) && $stable(cmp_dir_q) && $stable(cmp_pud_q);
  endsequence

  ack_single_a: assert property (req |=> ack_q ##1 !ack_q) // RULE4
    else $error("ack not a single pulse after request");

  foreign_block_a: assert property (s_foreign_wr |=> s_sel_hold) // RULE4
    else $error("foreign master changed configuration");

  pullup_write_a: assert property (wr_ok && hit_cmp_pud && wb_req.sel[0] && wb_req.dat[0] // RULE2
    |=> !cmp_pullup_en[0])
    else $error("pullup still on after disable write");

  reserved_mode_a: assert property (cmp_sel_q[3:2] == 2'h1 || cmp_sel_q[3:2] == 2'h2 // RULE7
    |=> !cmp_pin_oe[1])
    else $error("reserved mode drove a pin");

  comp_six_a: assert property (cmp_sel_q[5:4] == MODE_CMP // RULE6
    |=> cmp_pin_oe[2] && cmp_pin_o[2] == $past(comp_s_q[5]))
    else $error("third pin not carrying comparator 6");

  gpio_out_a: assert property (cmp_sel_q[1:0] == MODE_GPIO && cmp_dir_q[0] // RULE1
    |=> cmp_pin_oe[0] && cmp_pin_o[0] == $past(cmp_dat_q[0]))
    else $error("GPIO output not routed");

  ana_bit5_a: assert property (!ana_sel_q[5] // RULE13
    |=> !ana_analog_en[1] && ana_pin_oe[1] == $past(ana_dir_q[0]))
    else $error("pin A2 not in digital mode");

  even_ignore_a: assert property (wr_ok && hit_ana_sel // RULE14
    ##1 ((ana_sel_q ^ $past(ana_sel_q)) & 32'haaaaaaaa) == 32'h00000000
    |=> $stable(ana_analog_en))
    else $error("even select bit changed routing");

  fixed_analog_a: assert property (ana_analog_en[0] && !ana_pin_oe[0] && ana_analog_en[11]) // RULE17
    else $error("analog-only pin left analog mode");

  reset_state_a: assert property ($rose(rst_n) |-> cmp_pin_oe == 8'h00 // RULE3 RULE11
    && ana_analog_en == 12'hfff && ana_sel_q == RST_ANA_SEL)
    else $error("reset state not analog");

endmodule : acpm_top

`default_nettype wire

// >>> pkg/acpm_pkg.sv
// Constants and types for the comparator and analog pin multiplexer.
// Assumes a classic Wishbone register bus with 32-bit data on core_clk.
package acpm_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned CMP_PINS = 8;
  localparam int unsigned CMP_SRCS = 6;
  localparam int unsigned ANA_PINS = 12;
  localparam int unsigned ANA_DIGS = 6;
  localparam int unsigned ADR_W = 8;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CMP_SEL = 8'h00;
  localparam logic [7:0] OFS_CMP_PUD = 8'h04;
  localparam logic [7:0] OFS_CMP_DAT = 8'h08;
  localparam logic [7:0] OFS_CMP_DIR = 8'h0c;
  localparam logic [7:0] OFS_ANA_SEL = 8'h10;
  localparam logic [7:0] OFS_ANA_DAT = 8'h14;
  localparam logic [7:0] OFS_ANA_DIR = 8'h18;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_CMP_SEL = 16'h0000;
  localparam logic [7:0] RST_CMP_PUD = 8'hff;
  localparam logic [7:0] RST_CMP_DAT = 8'h00;
  localparam logic [7:0] RST_CMP_DIR = 8'h00;
  localparam logic [31:0] RST_ANA_SEL = 32'haaaaaaaa;
  localparam logic [5:0] RST_ANA_DAT = 6'h00;
  localparam logic [5:0] RST_ANA_DIR = 6'h00;

  // ---------------------------------------------------------------
  // Field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_GPIO = 2'h0;
  localparam logic [1:0] MODE_CMP = 2'h3;
  localparam logic MODE_ANA_DIGITAL = 1'b0;
  localparam logic MODE_ANA_ANALOG = 1'b1;

  // Mode 3 source per comparator-group pin; NONE means no function
  localparam logic [2:0] SRC_NONE = 3'h7;
  localparam logic [23:0] CMP_SRC_MAP = {3'h4, SRC_NONE, 3'h3, 3'h2, 3'h1, 3'h5, 3'h0, SRC_NONE};

  // Signal number of each analog pin A0 A2 A3 A4 A6 A7 B0 B2 B3 B4 B6 B7
  localparam logic [47:0] ANA_NUM_MAP = {4'hf, 4'he, 4'hc, 4'hb, 4'ha, 4'h8,
                                         4'h7, 4'h6, 4'h4, 4'h3, 4'h2, 4'h0};
  // Digital-capable pins and the digital bit each one uses (7 = none)
  localparam logic [35:0] ANA_DIG_MAP = {3'h7, 3'h5, 3'h4, 3'h7, 3'h3, 3'h7,
                                         3'h7, 3'h2, 3'h1, 3'h7, 3'h0, 3'h7};
  localparam logic [2:0] DIG_NONE = 3'h7;

  // ---------------------------------------------------------------
  // Bus carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } acpm_wb_req_t;

endpackage : acpm_pkg

// >>> tb/acpm_partner.sv
// Model of the pads and comparators facing the pin multiplexer.
// Assumes the bench sets the outside pad levels and the comparator states.
`timescale 1ns/1ps
`default_nettype none

module acpm_partner
  import acpm_pkg::*;
(
  // Outside world levels set by the bench
  input wire logic [CMP_PINS-1:0] cmp_ext,
  input wire logic [ANA_PINS-1:0] ana_ext,
  input wire logic [CMP_SRCS-1:0] cmp_src,
  // Multiplexer pad side
  input wire logic [CMP_PINS-1:0] cmp_pin_o,
  input wire logic [CMP_PINS-1:0] cmp_pin_oe,
  input wire logic [CMP_PINS-1:0] cmp_pullup_en,
  input wire logic [ANA_PINS-1:0] ana_pin_o,
  input wire logic [ANA_PINS-1:0] ana_pin_oe,
  output logic [CMP_PINS-1:0] cmp_pin_i,
  output logic [ANA_PINS-1:0] ana_pin_i,
  output logic [CMP_SRCS-1:0] comparator_digital_output
);
  // Driver wins, then pullup, then the outside level
  assign cmp_pin_i = (cmp_pin_oe & cmp_pin_o) | (~cmp_pin_oe & (cmp_pullup_en | cmp_ext));
  // No pullup exists on this group
  assign ana_pin_i = (ana_pin_oe & ana_pin_o) | (~ana_pin_oe & ana_ext);
  assign comparator_digital_output = cmp_src;
endmodule : acpm_partner

`default_nettype wire

// >>> tb/tb_top.sv
// Directed testbench for the pin multiplexer over classic Wishbone.
// Assumes acpm_partner resolves pad levels and supplies comparator outputs.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import acpm_pkg::*;
;
  logic core_clk, rst_n, wb_ctl_cpu, wb_ack_o;
  acpm_wb_req_t wb_req;
  logic [31:0] wb_dat_o, q;
  logic [5:0] cmp_src;
  logic [7:0] cmp_ext, exp_o;
  logic [11:0] ana_ext;
  wire logic [5:0] cdo;
  wire logic [7:0] c_i, c_o, c_oe, c_pu;
  wire logic [11:0] a_i, a_o, a_oe, a_en;
  int error_cnt, tests_run, m;

  acpm_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_ctl_cpu(wb_ctl_cpu),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comparator_digital_output(cdo), .cmp_pin_i(c_i),
    .cmp_pin_o(c_o), .cmp_pin_oe(c_oe), .cmp_pullup_en(c_pu), .ana_pin_i(a_i), .ana_pin_o(a_o),
    .ana_pin_oe(a_oe), .ana_analog_en(a_en));
  acpm_partner part_u (.cmp_ext(cmp_ext), .ana_ext(ana_ext), .cmp_src(cmp_src), .cmp_pin_o(c_o),
    .cmp_pin_oe(c_oe), .cmp_pullup_en(c_pu), .ana_pin_o(a_o), .ana_pin_oe(a_oe), .cmp_pin_i(c_i),
    .ana_pin_i(a_i), .comparator_digital_output(cdo));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; waits for ack, takes data at that edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic cpu);
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    wb_ctl_cpu <= cpu;
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_req <= '0;
    wb_ctl_cpu <= 1'b0;
    @(posedge core_clk);
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 1'b1);
    chk(q, exp);
  endtask : rd_chk

  // Pin effects and synchronisers need a few edges
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #(100 * 4000);
    error_cnt++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    wb_req = '0;
    wb_ctl_cpu = 1'b0;
    cmp_src = 6'h2d;
    cmp_ext = 8'h3c;
    ana_ext = 12'h5a5;
    error_cnt = 0;
    tests_run = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    settle(0);
    chk(32'(c_oe), 32'h0);
    chk(32'(c_pu), 32'h0);
    chk(32'(a_oe), 32'h0);
    chk(32'(a_en), 32'hfff);
    rd_chk(OFS_CMP_SEL, 32'h0);
    rd_chk(OFS_CMP_PUD, 32'hff);
    rd_chk(OFS_ANA_SEL, 32'haaaaaaaa);
    wb(1'b1, OFS_CMP_PUD, 32'h0000000f, 1'b1);
    settle(1);
    chk(32'(c_pu), 32'hf0);
    // Foreign master must neither change nor see the registers
    wb(1'b1, OFS_CMP_PUD, 32'h000000ff, 1'b0);
    wb(1'b0, OFS_CMP_PUD, 32'h0, 1'b0);
    chk(q, 32'h0);
    rd_chk(OFS_CMP_PUD, 32'h0f);
    wb(1'b1, OFS_CMP_SEL, 32'hffffffff, 1'b1);
    rd_chk(OFS_CMP_SEL, 32'hffff);
    rd_chk(8'hfc, 32'h0);
    // Inputs: pins 4..7 pulled high, rest follow the outside
    wb(1'b1, OFS_CMP_SEL, 32'h0, 1'b1);
    settle(5);
    rd_chk(OFS_CMP_DAT, 32'hfc);
    wb(1'b1, OFS_CMP_DIR, 32'hff, 1'b1);
    wb(1'b1, OFS_CMP_DAT, 32'h5a, 1'b1);
    rd_chk(OFS_CMP_DIR, 32'hff);
    for (m = 0; m < 4; m++) begin
      wb(1'b1, OFS_CMP_SEL, {16'h0, {8{m[1:0]}}}, 1'b1);
      settle(4);
      exp_o = {cmp_src[4], 1'b0, cmp_src[3], cmp_src[2], cmp_src[1], cmp_src[5], cmp_src[0], 1'b0};
      if (m == 0) begin
        chk(32'(c_oe), 32'hff);
        chk(32'(c_o), 32'h5a);
      end else if (m == 3) begin
        chk(32'(c_oe), 32'hbe);
        chk(32'(c_o & c_oe), 32'(exp_o));
        @(posedge core_clk);
        cmp_src <= ~cmp_src;
      end else begin
        chk(32'(c_oe), 32'h0);
      end
    end
    settle(4);
    chk(32'(c_o & c_oe), 32'(~exp_o & 8'hbe));
    // Comparator 6 high so pin 2 differs from its data latch bit
    @(posedge core_clk);
    cmp_src <= ~cmp_src;
    // Pin 2 alone in mode 3, its neighbours in mode 0
    wb(1'b1, OFS_CMP_SEL, 32'h0030, 1'b1);
    settle(1);
    chk(32'(c_o), {24'h0, 5'h0b, cmp_src[5], 2'h2});
    // Analog group: odd bits pick digital, even bits ignored
    wb(1'b1, OFS_ANA_SEL, 32'h55555555, 1'b1);
    settle(1);
    chk(32'(a_en), 32'h965);
    wb(1'b1, OFS_ANA_SEL, 32'hffffffdf, 1'b1);
    settle(1);
    chk(32'(a_en), 32'hffd);
    wb(1'b1, OFS_ANA_SEL, 32'h0, 1'b1);
    settle(5);
    chk(32'(a_en), 32'h965);
    // Only even bits change here, so routing must stay put
    wb(1'b1, OFS_ANA_SEL, 32'h55555555, 1'b1);
    settle(1);
    chk(32'(a_en), 32'h965);
    rd_chk(OFS_ANA_DAT, 32'h28);
    wb(1'b1, OFS_ANA_DIR, 32'hffffffff, 1'b1);
    wb(1'b1, OFS_ANA_DAT, 32'h2a, 1'b1);
    settle(1);
    chk(32'(a_oe), 32'h69a);
    chk(32'(a_o & a_oe), 32'h488);
    rd_chk(OFS_ANA_DIR, 32'h3f);
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
